// ### src/fbc_cfg.svh
`ifndef FBC_CFG_SVH
`define FBC_CFG_SVH

// Software register offsets
`define FBC_OFS_CTRL    8'h00
`define FBC_OFS_ADDR    8'h04
`define FBC_OFS_WDATA   8'h08
`define FBC_OFS_STATUS  8'h0C
`define FBC_OFS_RDATA   8'h10
`define FBC_OFS_PINS    8'h14

// Field positions
`define FBC_CTRL_OP_LSB 0
`define FBC_ST_SEQ_BUSY 0
`define FBC_ST_ENG_BUSY 1
`define FBC_ST_PWR_DOWN 2
`define FBC_ST_REFUSED  3
`define FBC_PINS_WP     0

// Reset values
`define FBC_RST_ADDR    20'h00000
`define FBC_RST_WDATA   16'h0000
`define FBC_RST_WP_N    1'b0

// Command codes, low byte only
`define FBC_CMD_ARRAY   8'hFF
`define FBC_CMD_IDENT   8'h90
`define FBC_CMD_STATUS  8'h70
`define FBC_CMD_CLEAR   8'h50
`define FBC_CMD_WWRITE  8'h40
`define FBC_CMD_ERASE   8'h20
`define FBC_CMD_SUSPEND 8'hB0
`define FBC_CMD_CONFIRM 8'hD0
`define FBC_CMD_XSTATUS 8'h71
`define FBC_CMD_LOCK    8'h77
`define FBC_CMD_UPLOAD  8'h97

// Timing
`define FBC_CLK_PERIOD_NS 40
`define FBC_T_RECOVER_NS  300
`define FBC_RECOVER_CYC \
  ((`FBC_T_RECOVER_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)

`endif

// ### src/fbc_host.sv
// Summary of operation
// - Row address always strobed before column address
// - Second command cycle reuses open row page
// - Wait recovery time after power-down release
// - Identifier read uses address bit zero
// - Code FF selects array reads
// - Word write is 40 then address and data
// - Erase is 20 then D0 at block
// - Suspend B0, resume D0, any address
// - Code 71 selects extended status reads
// - Block lock is 77 then D0 at block
// - Upload lock bits with 97 then D0
`timescale 1ns/1ps
`default_nettype none
`include "fbc_cfg.svh"

module fbc_host #(
  parameter int ACT_CYCLES = 4
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  output var  logic [9:0]  flash_addr,
  output var  logic        ras_n,
  output var  logic        cas_n,
  output var  logic        oe_n,
  output var  logic        we_n,
  output var  logic        powerdown_reset_n,
  output var  logic        write_protect_n,
  output var  logic [15:0] dq_out,
  output var  logic        dq_oe_n,
  input  wire logic [15:0] dq_in,
  input  wire logic        engine_idle_od_n
);

  localparam logic [7:0] RECOVER_CYC = 8'(`FBC_RECOVER_CYC);

  // Shorter strobes would outrun the data sampler
  if (ACT_CYCLES < 4 || ACT_CYCLES > 255) begin : g_act_check
    $error("ACT_CYCLES must lie in 4..255");
  end

  fbc_pkg::fbc_state_type state;
  fbc_pkg::fbc_op_type    op;
  logic        phase;
  logic [7:0]  cnt;
  logic [19:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic        pd_active;
  logic        refused;
  logic        idle_s1;
  logic        idle_s2;
  logic        idle_s3;
  logic        engine_idle;
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  logic [15:0] dq_s3;
  logic        ctrl_wr;
  logic        ctrl_ok;
  logic        cur_read;
  logic        last_cycle;
  logic [15:0] cur_data;

  function automatic logic [7:0] first_code(input fbc_pkg::fbc_op_type o);
    case (o)
      fbc_pkg::FBC_OP_ARRAY:   first_code = `FBC_CMD_ARRAY;
      fbc_pkg::FBC_OP_IDENT:   first_code = `FBC_CMD_IDENT;
      fbc_pkg::FBC_OP_STATUS:  first_code = `FBC_CMD_STATUS;
      fbc_pkg::FBC_OP_CLEAR:   first_code = `FBC_CMD_CLEAR;
      fbc_pkg::FBC_OP_WWRITE:  first_code = `FBC_CMD_WWRITE;
      fbc_pkg::FBC_OP_ERASE:   first_code = `FBC_CMD_ERASE;
      fbc_pkg::FBC_OP_SUSPEND: first_code = `FBC_CMD_SUSPEND;
      fbc_pkg::FBC_OP_RESUME:  first_code = `FBC_CMD_CONFIRM;
      fbc_pkg::FBC_OP_XSTATUS: first_code = `FBC_CMD_XSTATUS;
      fbc_pkg::FBC_OP_LOCK:    first_code = `FBC_CMD_LOCK;
      fbc_pkg::FBC_OP_UPLOAD:  first_code = `FBC_CMD_UPLOAD;
      default:                 first_code = 8'h00;
    endcase
  endfunction

  function automatic logic two_cycle(input fbc_pkg::fbc_op_type o);
    case (o)
      fbc_pkg::FBC_OP_WWRITE,
      fbc_pkg::FBC_OP_ERASE,
      fbc_pkg::FBC_OP_LOCK,
      fbc_pkg::FBC_OP_UPLOAD: two_cycle = 1'b1;
      default:                two_cycle = 1'b0;
    endcase
  endfunction

  function automatic logic bus_op(input logic [3:0] o);
    bus_op = (o <= 4'hB);
  endfunction

  assign ctrl_wr  = reg_wr && (reg_addr == `FBC_OFS_CTRL);
  assign ctrl_ok  = (state == fbc_pkg::FBC_ST_IDLE) &&
                    (pd_active ? (reg_wdata[3:0] == 4'hD)
                               : (reg_wdata[3:0] <= 4'hC));
  assign cur_read = (op == fbc_pkg::FBC_OP_READ);
  assign last_cycle = !(two_cycle(op) && !phase);

  // Upper byte zero on command cycles; only word data uses it
  always_comb begin
    if (phase && op == fbc_pkg::FBC_OP_WWRITE) begin
      cur_data = wdata_reg;
    end else if (phase) begin
      cur_data = {8'h00, `FBC_CMD_CONFIRM};
    end else begin
      cur_data = {8'h00, first_code(op)};
    end
  end

  // Busy pin and data pins are asynchronous to mclk
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idle_s1     <= 1'b1;
      idle_s2     <= 1'b1;
      idle_s3     <= 1'b1;
      engine_idle <= 1'b1;
    end else begin
      idle_s1 <= engine_idle_od_n;
      idle_s2 <= idle_s1;
      idle_s3 <= idle_s2;
      if (idle_s2 == idle_s3) begin
        engine_idle <= idle_s3;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      dq_s3 <= 16'h0000;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // Software registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_reg        <= `FBC_RST_ADDR;
      wdata_reg       <= `FBC_RST_WDATA;
      write_protect_n <= `FBC_RST_WP_N;
    end else if (reg_wr) begin
      case (reg_addr)
        `FBC_OFS_ADDR:  addr_reg        <= reg_wdata[19:0];
        `FBC_OFS_WDATA: wdata_reg       <= reg_wdata[15:0];
        `FBC_OFS_PINS:  write_protect_n <= reg_wdata[`FBC_PINS_WP];
        default:        ;
      endcase
    end
  end

  // Refused orders stay flagged; a new refusal beats the clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      refused <= 1'b0;
    end else if (ctrl_wr && !ctrl_ok) begin
      refused <= 1'b1;
    end else if (reg_wr && reg_addr == `FBC_OFS_STATUS) begin
      refused <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `FBC_OFS_CTRL:   reg_rdata <= {28'h0000000, op};
        `FBC_OFS_ADDR:   reg_rdata <= {12'h000, addr_reg};
        `FBC_OFS_WDATA:  reg_rdata <= {16'h0000, wdata_reg};
        `FBC_OFS_STATUS: reg_rdata <= {28'h0000000, refused, pd_active,
                                       !engine_idle,
                                       state != fbc_pkg::FBC_ST_IDLE};
        `FBC_OFS_RDATA:  reg_rdata <= {16'h0000, rdata_reg};
        `FBC_OFS_PINS:   reg_rdata <= {31'h00000000, write_protect_n};
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Bus sequencer; all pins except write_protect_n change only here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state             <= fbc_pkg::FBC_ST_RECOVER;
      op                <= fbc_pkg::FBC_OP_READ;
      phase             <= 1'b0;
      cnt               <= 8'h00;
      pd_active         <= 1'b0;
      powerdown_reset_n <= 1'b0;
      flash_addr        <= 10'h000;
      ras_n             <= 1'b1;
      cas_n             <= 1'b1;
      oe_n              <= 1'b1;
      we_n              <= 1'b1;
      dq_out            <= 16'h0000;
      dq_oe_n           <= 1'b1;
      rdata_reg         <= 16'h0000;
    end else begin
      case (state)
        fbc_pkg::FBC_ST_IDLE: begin
          if (ctrl_wr && ctrl_ok) begin
            op    <= fbc_pkg::fbc_op_type'(reg_wdata[3:0]);
            phase <= 1'b0;
            if (bus_op(reg_wdata[3:0])) begin
              state <= fbc_pkg::FBC_ST_ROW;
            end else if (reg_wdata[3:0] == 4'hC) begin
              powerdown_reset_n <= 1'b0;
              pd_active         <= 1'b1;
            end else begin
              powerdown_reset_n <= 1'b1;
              cnt               <= 8'h00;
              state             <= fbc_pkg::FBC_ST_RECOVER;
            end
          end
        end
        fbc_pkg::FBC_ST_ROW: begin
          flash_addr <= addr_reg[19:10];
          state      <= fbc_pkg::FBC_ST_RAS;
        end
        fbc_pkg::FBC_ST_RAS: begin
          ras_n <= 1'b0;
          state <= fbc_pkg::FBC_ST_CADR;
        end
        fbc_pkg::FBC_ST_CADR: begin
          flash_addr <= addr_reg[9:0];
          if (!cur_read) begin
            dq_out  <= cur_data;
            dq_oe_n <= 1'b0;
          end
          state <= fbc_pkg::FBC_ST_CAS;
        end
        fbc_pkg::FBC_ST_CAS: begin
          cas_n <= 1'b0;
          oe_n  <= !cur_read;
          we_n  <= cur_read;
          cnt   <= 8'h01;
          state <= fbc_pkg::FBC_ST_HOLD;
        end
        fbc_pkg::FBC_ST_HOLD: begin
          // Three-stage data sampler needs the extra hold cycles
          if (cnt < 8'(ACT_CYCLES)) begin
            cnt <= cnt + 8'h01;
          end else if (!cur_read || dq_s2 == dq_s3) begin
            if (cur_read) begin
              rdata_reg <= dq_s3;
            end
            cas_n <= 1'b1;
            oe_n  <= 1'b1;
            we_n  <= 1'b1;
            state <= fbc_pkg::FBC_ST_END;
          end
        end
        fbc_pkg::FBC_ST_END: begin
          dq_oe_n <= 1'b1;
          if (!last_cycle) begin
            phase <= 1'b1;
            state <= fbc_pkg::FBC_ST_CADR;
          end else begin
            ras_n <= 1'b1;
            state <= fbc_pkg::FBC_ST_IDLE;
          end
        end
        fbc_pkg::FBC_ST_RECOVER: begin
          powerdown_reset_n <= 1'b1;
          pd_active         <= 1'b0;
          if (cnt >= RECOVER_CYC) begin
            state <= fbc_pkg::FBC_ST_IDLE;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          state <= fbc_pkg::FBC_ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### src/fbc_pkg.sv
`default_nettype none
package fbc_pkg;

  typedef enum logic [3:0] {
    FBC_OP_READ    = 4'h0,
    FBC_OP_ARRAY   = 4'h1,
    FBC_OP_IDENT   = 4'h2,
    FBC_OP_STATUS  = 4'h3,
    FBC_OP_CLEAR   = 4'h4,
    FBC_OP_WWRITE  = 4'h5,
    FBC_OP_ERASE   = 4'h6,
    FBC_OP_SUSPEND = 4'h7,
    FBC_OP_RESUME  = 4'h8,
    FBC_OP_XSTATUS = 4'h9,
    FBC_OP_LOCK    = 4'hA,
    FBC_OP_UPLOAD  = 4'hB,
    FBC_OP_PD_IN   = 4'hC,
    FBC_OP_PD_OUT  = 4'hD
  } fbc_op_type;

  typedef enum logic [2:0] {
    FBC_ST_IDLE    = 3'b000,
    FBC_ST_ROW     = 3'b001,
    FBC_ST_RAS     = 3'b010,
    FBC_ST_CADR    = 3'b011,
    FBC_ST_CAS     = 3'b100,
    FBC_ST_HOLD    = 3'b101,
    FBC_ST_END     = 3'b110,
    FBC_ST_RECOVER = 3'b111
  } fbc_state_type;

endpackage
`default_nettype wire

// ### tb/fbc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model #(
  parameter logic [15:0] MAKER_CODE  = 16'h1357, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h2468  // Arbitrary value
) (
  input  wire logic [9:0]  flash_addr,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        powerdown_reset_n,
  input  wire logic        write_protect_n,
  input  wire logic [15:0] dq_out,
  output var  logic [15:0] dq_in,
  output wire logic        engine_idle_od_n
);
  logic [9:0]  row, col;
  logic [15:0] mem [1024];
  logic [15:0] rv, last;
  logic [31:0] lockd;
  logic [7:0]  pend;
  logic [1:0]  mode;
  logic        susp, ok, supply_ok, err_w, err_e;
  int          busy_cnt;
  wire         drv, busy;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    lockd = 32'hFFFFFFFF;
    {pend, mode, susp, last, rv, busy_cnt, supply_ok, err_w, err_e} = '0;
    supply_ok = 1'b1;
  end
  assign busy = busy_cnt != 0 && !susp;
  assign engine_idle_od_n = busy && powerdown_reset_n ? 1'b0 : 1'b1;
  assign drv = powerdown_reset_n && !ras_n && !cas_n && !oe_n && we_n;
  assign dq_in = drv ? rv : ~last; // Floating bus shows no stale data
  always @(negedge drv) last = rv;
  always #100 if (busy) busy_cnt--;
  always @(negedge powerdown_reset_n)
    {pend, mode, susp, busy_cnt, err_w, err_e} = '0;
  always @(negedge ras_n) row = flash_addr;
  always @(negedge cas_n) begin
    #1; // Enables switch in the same step as the strobe
    col = flash_addr;
    ok = supply_ok && (write_protect_n || !lockd[row[9:5]]);
    if (!ras_n && !we_n && powerdown_reset_n) begin
      if (pend == 8'h40 || pend == 8'h10) begin
        if (ok) mem[col] = dq_out;
        else err_w = 1'b1;
        mode = 2'd2;
        pend = 8'h00;
      end else if (pend != 8'h00) begin
        if (dq_out[7:0] == 8'hD0) begin
          case (pend)
            8'h20: if (ok) begin mem[col] = 16'hFFFF; busy_cnt = 20; end
              else err_e = 1'b1;
            8'h77: lockd[row[9:5]] = 1'b1;
            default: lockd = 32'h0;
          endcase
          if (pend == 8'h20) mode = 2'd2;
        end
        pend = 8'h00;
      end else begin
        case (dq_out[7:0])
          8'hFF: mode = 2'd0;
          8'h90: mode = 2'd1;
          8'h70: mode = 2'd2;
          8'h71: mode = 2'd3;
          8'h40, 8'h10, 8'h20, 8'h77, 8'h97: pend = dq_out[7:0];
          8'hB0: begin susp = 1'b1; mode = 2'd2; end
          8'hD0: susp = 1'b0;
          8'h50: {err_w, err_e} = 2'b00;
          default: ;
        endcase
      end
    end
    case (mode)
      2'd0: rv = mem[col];
      2'd1: rv = col[0] ? DEVICE_CODE : MAKER_CODE;
      default: rv = {8'h00, ~busy, susp, err_e, err_w, 4'h0};
    endcase
  end
endmodule
`default_nettype wire

// ### tb/fbc_host_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fbc_host_sva #(
  parameter int ACT_CYCLES = 4
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [9:0]  flash_addr,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        powerdown_reset_n,
  input wire logic        dq_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] low_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= cas_n ? 8'h00 : low_cnt + 8'h01;
    end
  end
  sequence s_row_open; $fell(ras_n); endsequence
  sequence s_col_strobe; ##[1:4] $fell(cas_n); endsequence
  property p_row_first; $fell(cas_n) |-> $past(ras_n) == 1'b0; endproperty
  a_row_first: assert property (p_row_first)
    else $error("column strobe without open row");
  property p_ras_to_cas; s_row_open |-> s_col_strobe; endproperty
  a_ras_to_cas: assert property (p_ras_to_cas)
    else $error("no column strobe after row strobe");
  property p_one_dir; $fell(cas_n) |-> we_n != oe_n; endproperty
  a_one_dir: assert property (p_one_dir)
    else $error("cycle neither read nor write");
  property p_no_fight; !oe_n |-> dq_oe_n && we_n; endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("data driven during read");
  property p_addr_hold;
    !cas_n && $past(cas_n) == 1'b0 |-> $stable({flash_addr, we_n, oe_n});
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address or enables moved under column strobe");
  property p_cas_width; $rose(cas_n) |-> low_cnt == ACT_CYCLES; endproperty
  a_cas_width: assert property (p_cas_width)
    else $error("column strobe width wrong");
  property p_recover; $rose(powerdown_reset_n) |-> ras_n [*8]; endproperty
  a_recover: assert property (p_recover)
    else $error("row strobe inside recovery time");
  property p_pd_quiet; !powerdown_reset_n |-> ras_n && cas_n; endproperty
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("strobe during power-down");
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
endmodule
bind fbc_host fbc_host_sva #(.ACT_CYCLES(ACT_CYCLES)) i_sva (
  .mclk(mclk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .flash_addr(flash_addr), .ras_n(ras_n), .cas_n(cas_n), .oe_n(oe_n),
  .we_n(we_n), .powerdown_reset_n(powerdown_reset_n), .dq_oe_n(dq_oe_n));
`default_nettype wire

// ### tb/fbc_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fbc_host_tb_top;
  logic        mclk, rst, reg_wr, reg_rd, ras_n, cas_n, oe_n, we_n;
  logic        powerdown_reset_n, write_protect_n, dq_oe_n, idle_n;
  logic [7:0]  reg_addr;
  logic [9:0]  flash_addr;
  logic [15:0] dq_out, dq_in;
  logic [31:0] reg_wdata, reg_rdata, v;
  int          fails, cmp_count, cyc;
  fbc_host i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_addr(flash_addr), .ras_n(ras_n),
    .cas_n(cas_n), .oe_n(oe_n), .we_n(we_n),
    .powerdown_reset_n(powerdown_reset_n),
    .write_protect_n(write_protect_n), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .dq_in(dq_in), .engine_idle_od_n(idle_n));
  fbc_flash_model i_dev (.flash_addr(flash_addr), .ras_n(ras_n),
    .cas_n(cas_n), .oe_n(oe_n), .we_n(we_n),
    .powerdown_reset_n(powerdown_reset_n),
    .write_protect_n(write_protect_n), .dq_out(dq_out),
    .dq_in(dq_in), .engine_idle_od_n(idle_n));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic print_verdict;
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk) reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk) reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask
  task automatic op(input logic [3:0] o);
    wr(8'h00, {28'h0, o});
    repeat (40) begin
      rd(8'h0C);
      if (v[0] === 1'b0) break;
    end
    chk({31'h0, v[0]}, 32'h0);
  endtask
  task automatic rdarr(input logic [31:0] e);
    op(4'h0);
    rdchk(8'h10, e);
  endtask
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, fails, cmp_count, cyc} = '0;
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (14) @(posedge mclk);
    rdchk(8'h0C, 32'h0);
    wr(8'h04, 32'h5); wr(8'h08, 32'h1234); op(4'h5);
    rdarr(32'h90);
    op(4'h1); rdarr(32'hFFFF);
    op(4'hB); op(4'h5); op(4'h1); rdarr(32'h1234);
    rdarr(32'h1234);
    $display("test write done");
    wr(8'h04, 32'h0); op(4'h2); rdarr(32'h1357);
    wr(8'h04, 32'h1); rdarr(32'h2468);
    op(4'h9); rdarr(32'h90);
    op(4'h3); rdarr(32'h90);
    op(4'h4); rdarr(32'h80);
    $display("test read modes done");
    wr(8'h04, 32'h5); op(4'hA); op(4'h6); op(4'h1);
    rdarr(32'h1234);
    wr(8'h14, 32'h1); rdchk(8'h14, 32'h1);
    op(4'h6); rdchk(8'h0C, 32'h2);
    rdarr(32'h20);
    op(4'h7); rdchk(8'h0C, 32'h0);
    op(4'h8);
    repeat (100) begin
      rd(8'h0C);
      if (v[1] === 1'b0) break;
    end
    chk({31'h0, v[1]}, 32'h0);
    op(4'h1); rdarr(32'hFFFF);
    $display("test erase done");
    wr(8'h00, 32'hE); rdchk(8'h0C, 32'h8);
    wr(8'h0C, 32'h0); rdchk(8'h0C, 32'h0);
    rdchk(8'h18, 32'h0);
    op(4'hC); rdchk(8'h0C, 32'h4);
    chk({31'h0, powerdown_reset_n}, 32'h0);
    op(4'h1); rdchk(8'h0C, 32'hC);
    wr(8'h0C, 32'h0); op(4'hD); rdarr(32'hFFFF);
    $display("test power-down done");
    print_verdict();
  end
endmodule
`default_nettype wire
